/* File: core/fsr_pkg.sv */
`default_nettype none
package fsr_pkg;

   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   localparam logic [7:0]  FSR_CMD_BYTE       = 8'h78;
   localparam logic [7:0]  FSR_CMD_WORD       = 8'h79;

   // ---------------------------------------------------------------
   // clear patterns and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  FSR_CLR_BUSY_BYTE  = 8'h80;
   localparam logic [15:0] FSR_CLR_BUSY_WORD  = 16'h0080;
   localparam logic [15:0] FSR_CLR_BOTH_WORD  = 16'h0180;
   localparam logic [15:0] FSR_WORD_RESET     = 16'h0000;
   localparam logic [7:0]  FSR_BYTE_ZERO      = 8'h00;

   // ---------------------------------------------------------------
   // bit positions of the summary word
   // ---------------------------------------------------------------
   localparam int FSR_BIT_BUSY     = 7;
   localparam int FSR_BIT_OFF      = 6;
   localparam int FSR_BIT_OVERV    = 5;
   localparam int FSR_BIT_OVERI    = 4;
   localparam int FSR_BIT_UNDERV   = 3;
   localparam int FSR_BIT_TEMP     = 2;
   localparam int FSR_BIT_COMM     = 1;
   localparam int FSR_BIT_UNLISTED = 0;
   localparam int FSR_BIT_VGRP     = 15;
   localparam int FSR_BIT_IGRP     = 14;
   localparam int FSR_BIT_INPUT    = 13;
   localparam int FSR_BIT_VENDOR   = 12;
   localparam int FSR_BIT_PWRGD    = 11;
   localparam int FSR_BIT_RSVD10   = 10;
   localparam int FSR_BIT_OTHER    = 9;
   localparam int FSR_BIT_RSVD8    = 8;

   // ---------------------------------------------------------------
   // synchroniser depth
   // ---------------------------------------------------------------
   localparam int FSR_SYNC_STAGES  = 2;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic output_overvoltage_summary;
      logic output_overcurrent_summary;
      logic input_undervoltage_summary;
      logic temp_any;
      logic comm_memory_logic_summary;
      logic output_voltage_group_flag;
      logic output_current_group_flag;
      logic input_group_flag;
      logic vendor_group_flag;
      logic other_group_flag;
   } fsr_detail_t;

   typedef struct packed {
      logic        write;
      logic [7:0]  code;
      logic [15:0] data;
   } fsr_cmd_t;

   typedef struct packed {
      logic [15:0] data;
      logic        supported;
   } fsr_rsp_t;

endpackage
`default_nettype wire

/* File: core/fsr_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module fsr_sync
   import fsr_pkg::*;
#(
   parameter int WIDTH  = 1,
   parameter int STAGES = FSR_SYNC_STAGES
)(
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] chain_reg [STAGES];

   // ---------------------------------------------------------------
   // flop chain, first stage read only by the next
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < STAGES; i++) begin
            chain_reg[i] <= '0;
         end
      end else begin
         chain_reg[0] <= d;
         for (int i = 1; i < STAGES; i++) begin
            chain_reg[i] <= chain_reg[i-1];
         end
      end
   end

   assign q = chain_reg[STAGES-1];

endmodule // fsr_sync
`default_nettype wire

/* File: core/fsr_status_regs.sv */
// Contract
// - bit 7 sets when a fault was declared for being busy, else zero
// - bit 6 live: one whenever not converting power, zero while converting
// - bits 5, 4, 3 report output OV, output OC, input UV faults
// - bit 2 reports any temperature fault or warning
// - bit 1 reports a communication, memory or logic fault
// - bit 0 reports a fault not covered by the other byte bits
// - 80h byte or 0080h word clears busy; 0180h clears busy and unknown
// - word bits 7:0 are the same storage as the summary byte
// - word bit 15 reports an output voltage related fault
// - word bit 14 reports an output current related fault
// - word bit 13 reports an input related fault
// - word bit 12 reports a vendor defined fault
// - word bit 11 live, follows the power-good pin assertion
// - word bit 9 reports a miscellaneous other fault
// - word bits 10 and 8 always read zero
// - every alert-capable summary bit has a matching mask bit
// - non-busy bits change only through their source detail flags or the not-converting and power-good pins
`timescale 1ns/1ps
`default_nettype none
module fsr_status_regs
   import fsr_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        clk_link,
   input  wire fsr_detail_t detail,
   input  wire logic        busy_fault_evt,
   input  wire logic        unknown_fault_evt,
   input  wire logic        not_converting_pin,
   input  wire logic        power_good_pin,
   input  wire logic [15:0] alert_mask,
   input  wire logic        cmd_req,
   input  wire fsr_cmd_t    cmd,
   output var  logic        cmd_ready,
   output var  logic        cmd_done,
   output var  fsr_rsp_t    rsp,
   output var  logic        alert_request,
   output var  logic        busy_flag,
   output var  logic        unknown_flag
);

   // ---------------------------------------------------------------
   // summary word composition
   // ---------------------------------------------------------------
   function automatic logic [15:0] fsr_compose(
      input fsr_detail_t d,
      input logic        busy,
      input logic        off,
      input logic        pg
   );
      logic [15:0] w;
      w = FSR_WORD_RESET;
      w[FSR_BIT_BUSY]     = busy;
      w[FSR_BIT_OFF]      = off;
      w[FSR_BIT_OVERV]    = d.output_overvoltage_summary;
      w[FSR_BIT_OVERI]    = d.output_overcurrent_summary;
      w[FSR_BIT_UNDERV]   = d.input_undervoltage_summary;
      w[FSR_BIT_TEMP]     = d.temp_any;
      w[FSR_BIT_COMM]     = d.comm_memory_logic_summary;
      w[FSR_BIT_UNLISTED] =
         (d.output_voltage_group_flag
            & ~d.output_overvoltage_summary)
         | (d.output_current_group_flag
            & ~d.output_overcurrent_summary)
         | (d.input_group_flag & ~d.input_undervoltage_summary)
         | d.vendor_group_flag
         | d.other_group_flag;
      w[FSR_BIT_VGRP]     = d.output_voltage_group_flag;
      w[FSR_BIT_IGRP]     = d.output_current_group_flag;
      w[FSR_BIT_INPUT]    = d.input_group_flag;
      w[FSR_BIT_VENDOR]   = d.vendor_group_flag;
      w[FSR_BIT_PWRGD]    = pg;
      w[FSR_BIT_OTHER]    = d.other_group_flag;
      w[FSR_BIT_RSVD10]   = 1'b0;
      w[FSR_BIT_RSVD8]    = 1'b0;
      return w;
   endfunction

   // ---------------------------------------------------------------
   // link domain: command capture
   // ---------------------------------------------------------------
   logic     req_tgl_reg;
   logic     ack_tgl_reg;
   logic     ack_seen_reg;
   logic     ack_sync;
   fsr_rsp_t rsp_sys_reg;
   fsr_cmd_t cmd_hold_reg;
   fsr_rsp_t rsp_link_reg;
   logic     done_reg;
   logic     take_cmd;

   assign cmd_ready = (req_tgl_reg == ack_seen_reg);
   assign take_cmd  = cmd_req & cmd_ready;

   always_ff @(posedge clk_link or negedge nrst) begin
      if (!nrst) begin
         req_tgl_reg  <= 1'b0;
         cmd_hold_reg <= '0;
      end else if (take_cmd) begin
         req_tgl_reg  <= ~req_tgl_reg;
         cmd_hold_reg <= cmd;
      end
   end

   fsr_sync #(
      .WIDTH  (1),
      .STAGES (FSR_SYNC_STAGES)
   ) u_ack_sync (
      .clk  (clk_link),
      .nrst (nrst),
      .d    (ack_tgl_reg),
      .q    (ack_sync)
   );

   // ---------------------------------------------------------------
   // link domain: answer return
   // ---------------------------------------------------------------
   always_ff @(posedge clk_link or negedge nrst) begin
      if (!nrst) begin
         ack_seen_reg <= 1'b0;
         done_reg     <= 1'b0;
         rsp_link_reg <= '0;
      end else begin
         ack_seen_reg <= ack_sync;
         done_reg     <= (ack_sync != ack_seen_reg);
         if (ack_sync != ack_seen_reg) begin
            rsp_link_reg <= rsp_sys_reg;
         end
      end
   end

   assign cmd_done = done_reg;
   assign rsp      = rsp_link_reg;

   // ---------------------------------------------------------------
   // system domain: pin and request synchronisers
   // ---------------------------------------------------------------
   logic [1:0] pins_sync;
   logic       off_live;
   logic       pg_live;
   logic       req_sync;
   logic       req_seen_reg;
   logic       req_new;

   fsr_sync #(
      .WIDTH  (2),
      .STAGES (FSR_SYNC_STAGES)
   ) u_pin_sync (
      .clk  (clk_sys),
      .nrst (nrst),
      .d    ({not_converting_pin, power_good_pin}),
      .q    (pins_sync)
   );

   assign off_live = pins_sync[1];
   assign pg_live  = pins_sync[0];

   fsr_sync #(
      .WIDTH  (1),
      .STAGES (FSR_SYNC_STAGES)
   ) u_req_sync (
      .clk  (clk_sys),
      .nrst (nrst),
      .d    (req_tgl_reg),
      .q    (req_sync)
   );

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         req_seen_reg <= 1'b0;
      end else begin
         req_seen_reg <= req_sync;
      end
   end

   assign req_new = (req_sync != req_seen_reg);

   // ---------------------------------------------------------------
   // write decode
   // ---------------------------------------------------------------
   logic is_byte;
   logic is_word;
   logic clr_busy;
   logic clr_unknown;

   assign is_byte = (cmd_hold_reg.code == FSR_CMD_BYTE);
   assign is_word = (cmd_hold_reg.code == FSR_CMD_WORD);

   assign clr_busy = req_new & cmd_hold_reg.write
      & ((is_byte & (cmd_hold_reg.data[7:0] == FSR_CLR_BUSY_BYTE))
         | (is_word & ((cmd_hold_reg.data == FSR_CLR_BUSY_WORD)
                       | (cmd_hold_reg.data == FSR_CLR_BOTH_WORD))));
   assign clr_unknown = req_new & cmd_hold_reg.write & is_word
      & (cmd_hold_reg.data == FSR_CLR_BOTH_WORD);

   // ---------------------------------------------------------------
   // busy and unknown flags, a new event beats a clear
   // ---------------------------------------------------------------
   logic busy_reg;
   logic unknown_reg;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= busy_fault_evt | (busy_reg & ~clr_busy);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         unknown_reg <= 1'b0;
      end else begin
         unknown_reg <= unknown_fault_evt
                      | (unknown_reg & ~clr_unknown);
      end
   end

   assign busy_flag    = busy_reg;
   assign unknown_flag = unknown_reg;

   // ---------------------------------------------------------------
   // live summary, read snapshot and answer
   // ---------------------------------------------------------------
   logic [15:0] status_live;

   // sources only, no write path into non-busy bits
   assign status_live = fsr_compose(detail, busy_reg,
                                    off_live, pg_live);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rsp_sys_reg <= '0;
      end else if (req_new) begin
         rsp_sys_reg.supported <= is_byte | is_word;
         rsp_sys_reg.data      <= FSR_WORD_RESET;
         if (!cmd_hold_reg.write) begin
            unique case (1'b1)
               is_byte: begin
                  rsp_sys_reg.data <= {FSR_BYTE_ZERO,
                                       status_live[7:0]};
               end
               is_word: begin
                  rsp_sys_reg.data <= status_live;
               end
               default: begin
                  rsp_sys_reg.data <= FSR_WORD_RESET;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ack_tgl_reg <= 1'b0;
      end else if (req_new) begin
         ack_tgl_reg <= ~ack_tgl_reg;
      end
   end

   // ---------------------------------------------------------------
   // alert request through mask
   // ---------------------------------------------------------------
   logic alert_reg;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         alert_reg <= 1'b0;
      end else begin
         alert_reg <= |(status_live & ~alert_mask);
      end
   end

   assign alert_request = alert_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb_sys @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence rd_take_s;
      req_new && !cmd_hold_reg.write;
   endsequence

   sequence byte_rd_s;
      rd_take_s ##0 is_byte;
   endsequence

   sequence word_rd_s;
      rd_take_s ##0 is_word;
   endsequence

   busy_set_a: assert property (
      busy_fault_evt |=> busy_flag ##1 (busy_flag || $past(clr_busy)))
      else $error("busy flag not set by busy event");

   off_live_a: assert property (
      word_rd_s |=> rsp_sys_reg.data[FSR_BIT_OFF] == $past(off_live))
      else $error("off bit does not follow live state");

   fault_bits_a: assert property (
      status_live[FSR_BIT_OVERV:FSR_BIT_UNDERV] ==
         {detail.output_overvoltage_summary,
          detail.output_overcurrent_summary,
          detail.input_undervoltage_summary})
      else $error("fault summary bits mismatch");

   temp_comm_a: assert property (
      status_live[FSR_BIT_TEMP] == detail.temp_any
      && status_live[FSR_BIT_COMM] == detail.comm_memory_logic_summary)
      else $error("temperature or comm logic bit mismatch");

   unlisted_vendor_a: assert property (
      (detail.vendor_group_flag || detail.other_group_flag)
         |-> status_live[FSR_BIT_UNLISTED])
      else $error("unlisted bit missed vendor or other fault");

   busy_clear_a: assert property (
      (clr_busy && !busy_fault_evt) |=> !busy_flag)
      else $error("busy not cleared by write pattern");

   unknown_clear_a: assert property (
      (clr_unknown && !unknown_fault_evt) |=> !unknown_flag)
      else $error("unknown not cleared by 0180h");

   odd_write_keep_a: assert property (
      (req_new && cmd_hold_reg.write && !clr_busy && busy_flag)
         |=> busy_flag)
      else $error("busy cleared by a non clearing write");

   byte_alias_a: assert property (
      byte_rd_s |=> rsp_sys_reg.data ==
         {FSR_BYTE_ZERO, $past(status_live[7:0])})
      else $error("byte read differs from word low byte");

   group_bits_a: assert property (
      status_live[FSR_BIT_VGRP:FSR_BIT_VENDOR] ==
         {detail.output_voltage_group_flag,
          detail.output_current_group_flag,
          detail.input_group_flag,
          detail.vendor_group_flag})
      else $error("group bits mismatch");

   power_good_a: assert property (
      word_rd_s |=> rsp_sys_reg.data[FSR_BIT_PWRGD] == $past(pg_live))
      else $error("power good bit does not follow pin");

   other_bit_a: assert property (
      status_live[FSR_BIT_OTHER] == detail.other_group_flag)
      else $error("other bit mismatch");

   rsvd_zero_a: assert property (
      !rsp_sys_reg.data[FSR_BIT_RSVD10] && !rsp_sys_reg.data[FSR_BIT_RSVD8])
      else $error("unsupported bits read non zero");

   alert_mask_a: assert property (
      1'b1 |=> alert_request == $past(|(status_live & ~alert_mask)))
      else $error("alert request ignores mask");

   read_answer_a: assert property (
      req_new |=> (ack_tgl_reg != $past(ack_tgl_reg)) ##1 !req_new)
      else $error("read not answered next cycle");

   done_pulse_a: assert property (
      @(posedge clk_link) disable iff (!nrst)
      cmd_done |=> !cmd_done && cmd_ready)
      else $error("done not a single pulse");

endmodule // fsr_status_regs
`default_nettype wire

/* File: testbench/fsr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model
   import fsr_pkg::*;
(
   input  wire logic     clk_link,
   input  wire logic     cmd_ready,
   input  wire logic     cmd_done,
   input  wire fsr_rsp_t rsp,
   output var  logic     cmd_req,
   output var  fsr_cmd_t cmd
);
   initial begin
      cmd_req = 1'b0;
      cmd     = '0;
   end

   // ---------------------------------------------------------------
   // one command: held until taken, answer picked up with done
   // ---------------------------------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] code,
                       input logic [15:0] data, output fsr_rsp_t r);
      int n;
      r = '1;
      @(posedge clk_link);
      cmd_req <= 1'b1;
      cmd     <= '{write: wr, code: code, data: data};
      n = 0;
      // ready looked at mid-cycle, so the next edge is the take edge
      @(negedge clk_link);
      while (cmd_ready !== 1'b1 && n < 40) begin
         @(negedge clk_link);
         n++;
      end
      @(posedge clk_link);
      cmd_req <= 1'b0;
      // released lines show the inverse, never the old value
      cmd     <= '{write: ~wr, code: ~code, data: ~data};
      for (int k = 0; k < 30; k++) begin
         @(posedge clk_link);
         #1;
         if (cmd_done === 1'b1) begin
            r = rsp;
            break;
         end
      end
   endtask
endmodule // fsr_host_model
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
   import fsr_pkg::*;
;
   logic        clk_sys;
   logic        clk_link;
   logic        nrst;
   fsr_detail_t detail;
   logic        busy_fault_evt;
   logic        unknown_fault_evt;
   logic        not_converting_pin;
   logic        power_good_pin;
   logic [15:0] alert_mask;
   logic        cmd_req;
   fsr_cmd_t    cmd;
   logic        cmd_ready;
   logic        cmd_done;
   fsr_rsp_t    rsp;
   logic        alert_request;
   logic        busy_flag;
   logic        unknown_flag;
   int          failures;
   int          checked;

   fsr_status_regs dut_u (
      .clk_sys            (clk_sys),
      .nrst               (nrst),
      .clk_link           (clk_link),
      .detail             (detail),
      .busy_fault_evt     (busy_fault_evt),
      .unknown_fault_evt  (unknown_fault_evt),
      .not_converting_pin (not_converting_pin),
      .power_good_pin     (power_good_pin),
      .alert_mask         (alert_mask),
      .cmd_req            (cmd_req),
      .cmd                (cmd),
      .cmd_ready          (cmd_ready),
      .cmd_done           (cmd_done),
      .rsp                (rsp),
      .alert_request      (alert_request),
      .busy_flag          (busy_flag),
      .unknown_flag       (unknown_flag)
   );

   fsr_host_model host_u (
      .clk_link  (clk_link),
      .cmd_ready (cmd_ready),
      .cmd_done  (cmd_done),
      .rsp       (rsp),
      .cmd_req   (cmd_req),
      .cmd       (cmd)
   );

   // ---------------------------------------------------------------
   // clocks, unrelated in phase
   // ---------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   initial begin
      clk_link = 1'b0;
      #1.7;
      forever #3 clk_link = ~clk_link;
   end

   // ---------------------------------------------------------------
   // expected summary word
   // ---------------------------------------------------------------
   function automatic logic [15:0] exp_w(input fsr_detail_t d,
                                         input logic b, input logic o,
                                         input logic p);
      logic u;
      u = (d.output_voltage_group_flag & ~d.output_overvoltage_summary)
        | (d.output_current_group_flag & ~d.output_overcurrent_summary)
        | (d.input_group_flag & ~d.input_undervoltage_summary)
        | d.vendor_group_flag | d.other_group_flag;
      return {d.output_voltage_group_flag, d.output_current_group_flag,
              d.input_group_flag, d.vendor_group_flag, p, 1'b0,
              d.other_group_flag, 1'b0, b, o,
              d.output_overvoltage_summary, d.output_overcurrent_summary,
              d.input_undervoltage_summary, d.temp_any,
              d.comm_memory_logic_summary, u};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      failures++;
      end_sim();
   end

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      fsr_rsp_t    r;
      fsr_detail_t d;
      logic [15:0] e;
      logic [7:0]  wc [4];
      logic [15:0] wv [4];
      wc = '{FSR_CMD_BYTE, FSR_CMD_WORD, FSR_CMD_WORD, FSR_CMD_WORD};
      wv = '{{8'h00, FSR_CLR_BUSY_BYTE}, FSR_CLR_BUSY_WORD, 16'h00FF,
             FSR_CLR_BOTH_WORD};
      failures = 0;
      checked = 0;
      nrst = 1'b0;
      detail = '0;
      busy_fault_evt = 1'b0;
      unknown_fault_evt = 1'b0;
      not_converting_pin = 1'b0;
      power_good_pin = 1'b0;
      alert_mask = 16'h0000;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      cyc(3);
      host_u.xfer(1'b0, FSR_CMD_WORD, 16'h0000, r);
      chk(r.data, FSR_WORD_RESET);
      chk({14'h0, busy_flag, alert_request}, 16'h0000);
      $display("test reset done");

      for (int i = 0; i < 10; i++) begin
         d = fsr_detail_t'(10'h001 << i);
         e = exp_w(d, 1'b0, 1'b0, 1'b0);
         @(posedge clk_sys);
         detail <= d;
         alert_mask <= 16'h0000;
         cyc(4);
         chk({15'h0, alert_request}, {15'h0, |e});
         host_u.xfer(1'b0, FSR_CMD_WORD, 16'h0000, r);
         chk(r.data, e);
         chk(r.data, e);
         host_u.xfer(1'b0, FSR_CMD_BYTE, 16'h0000, r);
         chk(r.data, {8'h00, e[7:0]});
         @(posedge clk_sys);
         alert_mask <= e;
         cyc(3);
         chk({15'h0, alert_request}, 16'h0000);
      end
      @(posedge clk_sys);
      detail <= '0;
      cyc(4);
      host_u.xfer(1'b0, FSR_CMD_WORD, 16'h0000, r);
      chk(r.data, 16'h0000);
      $display("test summary sources done");

      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys);
         not_converting_pin <= k[0];
         power_good_pin <= k[1];
         cyc(5);
         host_u.xfer(1'b0, FSR_CMD_WORD, 16'h0000, r);
         chk(r.data, exp_w('0, 1'b0, k[0], k[1]));
      end
      $display("test live bits done");

      for (int j = 0; j < 4; j++) begin
         @(posedge clk_sys);
         busy_fault_evt <= 1'b1;
         unknown_fault_evt <= 1'b1;
         @(posedge clk_sys);
         busy_fault_evt <= 1'b0;
         unknown_fault_evt <= 1'b0;
         cyc(2);
         chk({14'h0, busy_flag, unknown_flag}, 16'h0003);
         host_u.xfer(1'b0, FSR_CMD_WORD, 16'h0000, r);
         chk(r.data, exp_w('0, 1'b1, 1'b1, 1'b1));
         host_u.xfer(1'b1, wc[j], wv[j], r);
         chk({r.data[14:0], r.supported}, 16'h0001);
         cyc(3);
         chk({14'h0, busy_flag, unknown_flag},
             {14'h0, j == 2, j != 3});
         host_u.xfer(1'b0, FSR_CMD_BYTE, 16'h0000, r);
         chk(r.data, {8'h00, j == 2, 7'h40});
      end
      // unknown code: refused, clear pattern must not act
      @(posedge clk_sys);
      busy_fault_evt <= 1'b1;
      @(posedge clk_sys);
      busy_fault_evt <= 1'b0;
      host_u.xfer(1'b1, 8'h00, FSR_CLR_BUSY_WORD, r);
      chk({15'h0, r.supported}, 16'h0000);
      host_u.xfer(1'b0, 8'h00, 16'h0000, r);
      chk(r.data, 16'h0000);
      chk({15'h0, r.supported}, 16'h0000);
      cyc(3);
      chk({15'h0, busy_flag}, 16'h0001);
      $display("test busy clear done");
      end_sim();
   end
endmodule // testbench
`default_nettype wire
